// file: rtl/tcc_pkg.sv
// constants and types shared by the touch channel control register bank
`default_nettype none
package tcc_pkg;
    localparam logic [7:0]  ADR_CTRL2     = 8'h09;
    localparam logic [7:0]  ADR_RENEW_LO  = 8'h0A;
    localparam logic [7:0]  ADR_RENEW_HI  = 8'h0B;
    localparam logic [7:0]  ADR_PAUSE_LO  = 8'h0C;
    localparam logic [7:0]  ADR_PAUSE_HI  = 8'h0D;
    localparam logic [7:0]  ADR_FREEZE_LO = 8'h0E;
    localparam logic [7:0]  ADR_FREEZE_HI = 8'h0F;
    localparam logic [7:0]  ADR_LEVEL0    = 8'h10;
    localparam logic [7:0]  ADR_LEVEL1    = 8'h11;
    localparam logic [7:0]  ADR_LEVEL2    = 8'h12;
    localparam logic [7:0]  ADR_LEVEL3    = 8'h13;
    localparam logic [7:0]  ADR_KEY       = 8'h3B;
    localparam logic [7:0]  ADR_FORCE     = 8'h41;
    localparam logic [15:0] RST_RENEW     = 16'hFFFE;
    localparam logic [15:0] RST_PAUSE     = 16'hFFFE;
    localparam logic [15:0] RST_FREEZE    = 16'h0000;
    localparam logic [31:0] RST_LEVEL     = 32'h0000_0000;
    localparam logic [7:0]  RST_KEY       = 8'h00;
    localparam logic [7:0]  RST_CTRL2     = 8'h01;
    localparam logic [7:0]  RST_FORCE     = 8'h14;
    localparam logic [7:0]  KEY_UNLOCK    = 8'hA5;
    localparam int          BIT_MULTI     = 5;
    localparam int          BIT_FORCE     = 7;
    localparam logic [1:0]  LVL_NONE      = 2'h0;
    localparam logic [1:0]  LVL_LOW       = 2'h1;
    localparam logic [1:0]  LVL_MID       = 2'h2;
    localparam logic [1:0]  LVL_HIGH      = 2'h3;
    localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
    localparam logic [6:0]  I2C_ADDR_DEF  = 7'h68;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;

    // serial front end phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WR,
        ST_RD,
        ST_RACK
    } tcc_i2c_st_t;
endpackage : tcc_pkg
`default_nettype wire

// file: rtl/tcc_reg_if.sv
// register strobe and read path between serial front end and bank
`timescale 1ns/1ns
`default_nettype none
interface tcc_reg_if;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport master (output wr_stb, output wr_addr, output wr_data, output rd_addr,
                    input rd_data);
    modport bank   (input wr_stb, input wr_addr, input wr_data, input rd_addr,
                    output rd_data);
endinterface : tcc_reg_if
`default_nettype wire

// file: rtl/tcc_i2c_slave.sv
// serial slave front end turning bus bytes into register strobes and reads
`timescale 1ns/1ns
`default_nettype none
module tcc_i2c_slave
    import tcc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEF
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_oe,
    tcc_reg_if.master rb
);
    tcc_i2c_st_t st_ff, nxt_st;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic [7:0]  sh_ff, nxt_sh;
    logic [7:0]  ptr_ff, nxt_ptr;
    logic [7:0]  wa_ff, nxt_wa;
    logic [7:0]  wd_ff, nxt_wd;
    logic        scl_q_ff, sda_q_ff;
    logic        rw_ff, nxt_rw;
    logic        first_ff, nxt_first;
    logic        oe_ff, nxt_oe;
    logic        stb_ff, nxt_stb;
    logic        rise, fall, start, stop;

    // pins are synchronous, so one stage of history gives the edges
    assign rise  = scl_in & ~scl_q_ff;
    assign fall  = ~scl_in & scl_q_ff;
    assign start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    assign stop  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

    // bus phase sequencing; start and stop override any phase
    always_comb begin
        nxt_st    = st_ff;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_ptr   = ptr_ff;
        nxt_wa    = wa_ff;
        nxt_wd    = wd_ff;
        nxt_rw    = rw_ff;
        nxt_first = first_ff;
        nxt_oe    = oe_ff;
        nxt_stb   = 1'b0;
        if (start) begin
            nxt_st    = ST_ADDR;
            nxt_cnt   = 4'h0;
            nxt_first = 1'b1;
            nxt_oe    = 1'b0;
        end else if (stop) begin
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    nxt_oe = 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (rise) begin
                        nxt_sh  = {sh_ff[6:0], sda_in};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (fall && cnt_ff == BYTE_BITS) begin
                        nxt_cnt = 4'h0;
                        nxt_st  = ST_ACK;
                        nxt_oe  = 1'b1;
                        if (st_ff == ST_ADDR) begin
                            nxt_rw = sh_ff[0];
                            if (sh_ff[7:1] != DEV_ADDR) begin
                                nxt_st = ST_IDLE;
                                nxt_oe = 1'b0;
                            end
                        end else if (first_ff) begin
                            nxt_ptr   = sh_ff;
                            nxt_first = 1'b0;
                        end else begin
                            nxt_stb = 1'b1;
                            nxt_wa  = ptr_ff;
                            nxt_wd  = sh_ff;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (fall && rw_ff) begin
                        nxt_st = ST_RD;
                        nxt_sh = rb.rd_data;
                        nxt_oe = ~rb.rd_data[7];
                    end else if (fall) begin
                        nxt_st = ST_WR;
                        nxt_oe = 1'b0;
                    end
                end
                ST_RD: begin
                    if (rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (fall && cnt_ff == BYTE_BITS) begin
                        nxt_st  = ST_RACK;
                        nxt_oe  = 1'b0;
                        nxt_cnt = 4'h0;
                        nxt_ptr = ptr_ff + 8'h01;
                    end else if (fall) begin
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_oe = ~sh_ff[6];
                    end
                end
                ST_RACK: begin
                    // a nack ends the read; an ack loads the next byte
                    if (rise && sda_in) begin
                        nxt_st = ST_IDLE;
                    end else if (fall) begin
                        nxt_st = ST_RD;
                        nxt_sh = rb.rd_data;
                        nxt_oe = ~rb.rd_data[7];
                    end
                end
            endcase
        end
    end

    // state registers, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= ST_IDLE;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            ptr_ff   <= 8'h00;
            wa_ff    <= 8'h00;
            wd_ff    <= 8'h00;
            rw_ff    <= 1'b0;
            first_ff <= 1'b1;
            oe_ff    <= 1'b0;
            stb_ff   <= 1'b0;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else if (en) begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            ptr_ff   <= nxt_ptr;
            wa_ff    <= nxt_wa;
            wd_ff    <= nxt_wd;
            rw_ff    <= nxt_rw;
            first_ff <= nxt_first;
            oe_ff    <= nxt_oe;
            stb_ff   <= nxt_stb;
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    assign sda_oe     = oe_ff;
    assign rb.wr_stb  = stb_ff;
    assign rb.wr_addr = wa_ff;
    assign rb.wr_data = wd_ff;
    assign rb.rd_addr = ptr_ff;
endmodule : tcc_i2c_slave
`default_nettype wire

// file: rtl/touch_channel_control_regs.sv
// touch channel control register bank with serial slave access
//
// Contract
// - renew bit set renews that channel's reference
// - renew bits reset 1, channel 1 resets 0
// - pause bit stops sensing and calibration
// - pause bits reset 1, channel 1 resets 0
// - freeze bit stops calibration only, resets 0
// - two-bit level per channel, resets none
// - four levels per byte, lowest channel low
// - key register guards bits, resets zero
// - force bit selects touch mode, reset 14h
// - reset pin high holds device in reset; code resets the bank, not the serial slave, and only with clk_en high
// - output mode bit: 0 multiple, 1 single
`timescale 1ns/1ns
`default_nettype none
module touch_channel_control_regs
    import tcc_pkg::*;
#(
    parameter int         CH_N     = 16,
    parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        rst_pin,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [31:0] level_in,
    output logic [15:0]      baseline_renew,
    output logic [15:0]      sense_run,
    output logic [15:0]      cal_run,
    output logic             single_output,
    output logic             touch_mode_force_bit
);
    // the register map is fixed at sixteen channels
    if (CH_N != 16) begin : g_chk
        $error("touch_channel_control_regs serves exactly sixteen channels");
    end

    tcc_reg_if rb ();

    logic [15:0] renew_ff, nxt_renew;
    logic [15:0] pause_ff, nxt_pause;
    logic [15:0] freeze_ff, nxt_freeze;
    logic [15:0] sense_ff, nxt_sense;
    logic [15:0] cal_ff, nxt_cal;
    logic [31:0] level_ff, nxt_level;
    logic [7:0]  key_ff, nxt_key;
    logic [7:0]  ctrl2_ff, nxt_ctrl2;
    logic [7:0]  force_ff, nxt_force;
    logic        single_ff, nxt_single;
    logic        sda_lo_ff;
    logic        key_ok;
    logic [7:0]  rd_byte;

    // serial front end; it owns the pointer and the strobes
    tcc_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .clk    (clk),
        .rst_n  (rst_n),
        .en     (clk_en),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .sda_oe (sda_oe),
        .rb     (rb.master)
    );

    // two-bit level field of one channel in a packed word
    function automatic logic [1:0] lvl_of(input logic [31:0] v, input int ch);
        lvl_of = v[2*ch +: 2];
    endfunction : lvl_of

    assign key_ok = (key_ff == KEY_UNLOCK);

    // register writes, level capture and output-mode application
    always_comb begin
        nxt_renew  = renew_ff;
        nxt_pause  = pause_ff;
        nxt_freeze = freeze_ff;
        nxt_level  = level_ff;
        nxt_key    = key_ff;
        nxt_ctrl2  = ctrl2_ff;
        nxt_force  = force_ff;
        nxt_single = single_ff;
        if (rst_pin) begin
            nxt_renew  = RST_RENEW;
            nxt_pause  = RST_PAUSE;
            nxt_freeze = RST_FREEZE;
            nxt_level  = RST_LEVEL;
            nxt_key    = RST_KEY;
            nxt_ctrl2  = RST_CTRL2;
            nxt_force  = RST_FORCE;
            nxt_single = 1'b0;
        end else begin
            if (rb.wr_stb) begin
                case (rb.wr_addr)
                    ADR_CTRL2: begin
                        // noise can only flip the output mode bit when unlocked
                        nxt_ctrl2 = rb.wr_data;
                        if (!key_ok) begin
                            nxt_ctrl2[BIT_MULTI] = ctrl2_ff[BIT_MULTI];
                        end
                    end
                    ADR_RENEW_LO:  nxt_renew[7:0]   = rb.wr_data;
                    ADR_RENEW_HI:  nxt_renew[15:8]  = rb.wr_data;
                    ADR_PAUSE_LO:  nxt_pause[7:0]   = rb.wr_data;
                    ADR_PAUSE_HI:  nxt_pause[15:8]  = rb.wr_data;
                    ADR_FREEZE_LO: nxt_freeze[7:0]  = rb.wr_data;
                    ADR_FREEZE_HI: nxt_freeze[15:8] = rb.wr_data;
                    ADR_KEY:       nxt_key          = rb.wr_data;
                    ADR_FORCE:     nxt_force        = rb.wr_data;
                    // level registers and unmapped addresses drop the write
                    default: ;
                endcase
            end
            // a paused channel is not sensed and reports no touch
            for (int ch = 0; ch < 16; ch++) begin
                nxt_level[2*ch +: 2] = pause_ff[ch] ? LVL_NONE
                                                    : lvl_of(level_in, ch);
            end
            // mode bit takes effect only with the key and force bit both set
            if (key_ok && force_ff[BIT_FORCE]) begin
                nxt_single = ctrl2_ff[BIT_MULTI];
            end
        end
        nxt_sense = ~nxt_pause;
        nxt_cal   = ~nxt_pause & ~nxt_freeze;
    end

    // bank registers, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            renew_ff  <= RST_RENEW;
            pause_ff  <= RST_PAUSE;
            freeze_ff <= RST_FREEZE;
            sense_ff  <= ~RST_PAUSE;
            cal_ff    <= ~RST_PAUSE & ~RST_FREEZE;
            level_ff  <= RST_LEVEL;
            key_ff    <= RST_KEY;
            ctrl2_ff  <= RST_CTRL2;
            force_ff  <= RST_FORCE;
            single_ff <= 1'b0;
            sda_lo_ff <= 1'b0;
        end else if (clk_en) begin
            renew_ff  <= nxt_renew;
            pause_ff  <= nxt_pause;
            freeze_ff <= nxt_freeze;
            sense_ff  <= nxt_sense;
            cal_ff    <= nxt_cal;
            level_ff  <= nxt_level;
            key_ff    <= nxt_key;
            ctrl2_ff  <= nxt_ctrl2;
            force_ff  <= nxt_force;
            single_ff <= nxt_single;
            sda_lo_ff <= 1'b0;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        unique case (rb.rd_addr)
            ADR_CTRL2:     rd_byte = ctrl2_ff;
            ADR_RENEW_LO:  rd_byte = renew_ff[7:0];
            ADR_RENEW_HI:  rd_byte = renew_ff[15:8];
            ADR_PAUSE_LO:  rd_byte = pause_ff[7:0];
            ADR_PAUSE_HI:  rd_byte = pause_ff[15:8];
            ADR_FREEZE_LO: rd_byte = freeze_ff[7:0];
            ADR_FREEZE_HI: rd_byte = freeze_ff[15:8];
            ADR_LEVEL0:    rd_byte = level_ff[7:0];
            ADR_LEVEL1:    rd_byte = level_ff[15:8];
            ADR_LEVEL2:    rd_byte = level_ff[23:16];
            ADR_LEVEL3:    rd_byte = level_ff[31:24];
            ADR_KEY:       rd_byte = key_ff;
            ADR_FORCE:     rd_byte = force_ff;
            default:       rd_byte = RD_UNMAPPED;
        endcase
    end
    assign rb.rd_data = rd_byte;

    // the data pin only ever pulls low; the enable carries the bit
    assign sda_out              = sda_lo_ff;
    assign baseline_renew       = renew_ff;
    assign sense_run            = sense_ff;
    assign cal_run              = cal_ff;
    assign single_output        = single_ff;
    assign touch_mode_force_bit = force_ff[BIT_FORCE];

    // checks on the bank
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pin_reset;
        clk_en && rst_pin;
    endsequence

    sequence s_wr(logic [7:0] a);
        clk_en && !rst_pin && rb.wr_stb && rb.wr_addr == a;
    endsequence

    renew_reset_a: assert property (
        s_pin_reset |=> renew_ff == 16'hFFFE && pause_ff == 16'hFFFE)
        else $error("renew or pause reset value wrong");

    pin_reset_a: assert property (
        s_pin_reset |=> level_ff == 32'h0 && key_ff == 8'h00 && !single_ff)
        else $error("reset pin did not clear state");

    force_reset_a: assert property (
        s_pin_reset |=> force_ff == 8'h14 && !touch_mode_force_bit)
        else $error("force register reset value wrong");

    renew_write_a: assert property (
        s_wr(ADR_RENEW_HI) |=> baseline_renew[15:8] == $past(rb.wr_data))
        else $error("renew write not applied");

    pause_run_a: assert property (
        sense_run == ~pause_ff && (cal_run & pause_ff) == 16'h0)
        else $error("paused channel still runs");

    freeze_cal_a: assert property (
        cal_run == (~pause_ff & ~freeze_ff))
        else $error("calibration run mismatch");

    paused_level_a: assert property (
        clk_en && !rst_pin && pause_ff[4] |=> level_ff[9:8] == LVL_NONE)
        else $error("paused channel reports touch");

    level_pack_a: assert property (
        rb.rd_addr == ADR_LEVEL1 |-> rb.rd_data[1:0] == lvl_of(level_ff, 4))
        else $error("level packing wrong");

    level_ro_a: assert property (
        s_wr(ADR_LEVEL2) |=> $stable(renew_ff) && $stable(pause_ff) && $stable(key_ff))
        else $error("level write disturbed other registers");

    mode_guard_a: assert property (
        clk_en && !rst_pin && single_ff != ctrl2_ff[BIT_MULTI] && !key_ok
        |=> $stable(single_ff))
        else $error("output mode changed while locked");
endmodule : touch_channel_control_regs
`default_nettype wire

// file: testbench/tcc_host_model.sv
// serial bus host model that drives the clock and data lines of the register bank
`timescale 1ns/1ns
`default_nettype none
module tcc_host_model (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    // clocks of the low phase after the data change (one more in all); raise it to model a slow host
    int lo_cyc = 6;

    // both lines released while idle, the pull-up keeps them high
    initial begin
        scl     = 1'h1;
        sda_drv = 1'h1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask : hold

    // one bit slot; data changes only while the clock line is low
    task automatic bit_slot(input logic b, output logic r);
        hold(1);
        sda_drv = b;
        hold(lo_cyc);
        scl = 1'h1;
        hold(3);
        r = sda_wire;  // mid high phase, well clear of the device's change point
        hold(3);
        scl = 1'h0;
    endtask : bit_slot

    // start or repeated start: data falls while the clock is high
    task automatic start_c();
        sda_drv = 1'h1;
        hold(2);
        scl = 1'h1;
        hold(4);
        sda_drv = 1'h0;
        hold(4);
        scl = 1'h0;
    endtask : start_c

    // stop: data rises while the clock is high, then the bus stays idle
    task automatic stop_c();
        hold(1);
        sda_drv = 1'h0;
        hold(lo_cyc);
        scl = 1'h1;
        hold(4);
        sda_drv = 1'h1;
        hold(4);
    endtask : stop_c

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'h1, r);
        ack = ~r;
    endtask : send_byte

    // the host acknowledges every byte but the last of a read
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'h1, d[i]);
        end
        bit_slot(last, r);
    endtask : recv_byte
endmodule : tcc_host_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the touch channel control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tcc_pkg::*;
    logic        clk         = 1'h0;
    logic        rst_n       = 1'h0;
    logic        clk_en      = 1'h1;
    logic        rst_pin     = 1'h0;
    logic [31:0] level_in    = 32'h0;
    int          miscompares = 0;
    int          comparisons = 0;
    logic [6:0]  dev_adr     = I2C_ADDR_DEF;
    wire logic   scl;
    wire logic   sda_drv;
    wire logic   sda_in;
    logic        sda_out;
    logic        sda_oe;
    logic [15:0] baseline_renew;
    logic [15:0] sense_run;
    logic [15:0] cal_run;
    logic        single_output;
    logic        touch_mode_force_bit;

    // 250 MHz clock
    always #2 clk = ~clk;

    // open-drain data wire: low when either party pulls, else pulled up
    assign sda_in = sda_drv & ~sda_oe;

    touch_channel_control_regs dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .rst_pin(rst_pin), .scl_in(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .level_in(level_in),
        .baseline_renew(baseline_renew), .sense_run(sense_run), .cal_run(cal_run),
        .single_output(single_output), .touch_mode_force_bit(touch_mode_force_bit)
    );

    tcc_host_model host (.clk(clk), .sda_wire(sda_in), .scl(scl), .sda_drv(sda_drv));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // pointer then data bytes in one frame; pointer advances per byte
    task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
        logic a;
        host.start_c();
        host.send_byte({dev_adr, 1'h0}, a);
        host.send_byte(ptr, a);
        foreach (d[i]) begin
            host.send_byte(d[i], a);
        end
        host.stop_c();
    endtask : wr_regs

    // pointer frame closed by a stop, then a new start and a burst read compared byte by byte
    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e[$]);
        logic [7:0] b;
        logic       a;
        host.start_c();
        host.send_byte({I2C_ADDR_DEF, 1'h0}, a);
        host.send_byte(ptr, a);
        host.stop_c();
        host.start_c();
        host.send_byte({I2C_ADDR_DEF, 1'h1}, a);
        foreach (e[i]) begin
            host.recv_byte(i == e.size() - 1, b);
            check("read byte", {23'h0, sda_out, b}, {24'h0, e[i]});
        end
        host.stop_c();
    endtask : rd_chk

    task automatic outs_chk(input logic [15:0] rn, input logic [15:0] sr,
                            input logic [15:0] cr, input logic [1:0] md);
        repeat (2) @(negedge clk);
        check("baseline_renew", {16'h0, baseline_renew}, {16'h0, rn});
        check("sense_run", {16'h0, sense_run}, {16'h0, sr});
        check("cal_run", {16'h0, cal_run}, {16'h0, cr});
        check("mode bits", {30'h0, single_output, touch_mode_force_bit}, {30'h0, md});
    endtask : outs_chk

    // paused channels report no touch; four channels per byte, lowest in bits 1:0
    task automatic lvl_chk(input logic [15:0] pause);
        logic [31:0] e;
        logic [7:0]  q[$];
        e = level_in;
        for (int n = 0; n < 16; n++) begin
            if (pause[n]) e[2*n +: 2] = 2'h0;
        end
        for (int k = 0; k < 4; k++) begin
            q.push_back(e[8*k +: 8]);
        end
        rd_chk(8'h10, q);
    endtask : lvl_chk

    // a full run takes about 16k clocks; this cuts a hang well past that
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        outs_chk(16'hFFFE, 16'h0001, 16'h0001, 2'h0);
        rd_chk(8'h0A, '{8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'h00, 8'h00});
        rd_chk(8'h3B, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        rd_chk(8'h41, '{8'h14});
        lvl_chk(16'hFFFE);
        // burst across renew, pause and freeze pairs
        wr_regs(8'h0A, '{8'h5A, 8'hC3, 8'h0F, 8'hF0, 8'h33, 8'h11});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h0);
        rd_chk(8'h0A, '{8'h5A, 8'hC3, 8'h0F, 8'hF0, 8'h33, 8'h11});
        // a frame for another device address is ignored and changes nothing
        dev_adr = I2C_ADDR_DEF ^ 7'h01;
        wr_regs(8'h0A, '{8'h00});
        dev_adr = I2C_ADDR_DEF;
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h0);
        // every level code on running channels
        level_in = 32'h1BE4_E41B;
        lvl_chk(16'hF00F);
        wr_regs(8'h10, '{8'hFF, 8'h00, 8'hAA});
        lvl_chk(16'hF00F);
        wr_regs(8'h50, '{8'h77});
        rd_chk(8'h50, '{8'h00});
        // mode bit is dropped while the key is clear; reserved force bits keep 14h
        wr_regs(8'h09, '{8'h23});
        wr_regs(8'h41, '{8'h94});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h1);
        wr_regs(8'h3B, '{8'hA5});
        wr_regs(8'h09, '{8'h23});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h3);
        rd_chk(8'h3B, '{8'hA5});
        wr_regs(8'h09, '{8'h03});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h1);
        wr_regs(8'h3B, '{8'h00});
        wr_regs(8'h09, '{8'h23});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h1);
        rd_chk(8'h09, '{8'h03});
        // key set but force bit clear: the mode bit is stored, not applied
        wr_regs(8'h41, '{8'h14});
        wr_regs(8'h3B, '{8'hA5});
        wr_regs(8'h09, '{8'h23});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h0);
        // force bit set after the key is cleared still leaves the mode alone
        wr_regs(8'h3B, '{8'h00});
        wr_regs(8'h41, '{8'h94});
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h1);
        rd_chk(8'h09, '{8'h23});
        // reset pin is ignored while the clock enable is low
        clk_en  = 1'h0;
        rst_pin = 1'h1;
        repeat (3) @(negedge clk);
        rst_pin = 1'h0;
        clk_en  = 1'h1;
        outs_chk(16'hC35A, 16'h0FF0, 16'h0EC0, 2'h1);
        rst_pin = 1'h1;
        @(negedge clk);
        rst_pin = 1'h0;
        outs_chk(16'hFFFE, 16'h0001, 16'h0001, 2'h0);
        rd_chk(8'h3B, '{8'h00});
        rd_chk(8'h41, '{8'h14});
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
